/* cds_consts.svh */
`ifndef CDS_CONSTS_SVH
`define CDS_CONSTS_SVH

// ==========================================================
// timing
`define CDS_CLK_HZ          125000000
`define CDS_MS_PER_S        1000
`define CDS_MS_CYCLES       (`CDS_CLK_HZ / `CDS_MS_PER_S)
`define CDS_SEC_LAST_MS     10'd999
`define CDS_POWERUP_S       5
`define CDS_POWERUP_MS      (`CDS_POWERUP_S * `CDS_MS_PER_S)
`define CDS_LOAD_S          2
`define CDS_LOAD_MS         (`CDS_LOAD_S * `CDS_MS_PER_S)
`define CDS_BLINK_SLOT_MS   8'd250
`define CDS_BLINK_ON_MS     8'd125
`define CDS_BLINK_SLOTS     3'd6
`define CDS_FAST_BIT        6
`define CDS_LOAD_BIT        8
`define CDS_SLOW_HALF_MS    10'd500

// ==========================================================
// data path
`define CDS_PIX_W           16
`define CDS_LOG_BYTES       256

// ==========================================================
// register byte addresses
`define CDS_REG_LED         16'h1A14
`define CDS_REG_BLEM        16'h1A60
`define CDS_REG_UPTIME      16'h1A80
`define CDS_REG_LINKUP      16'h1A84
`define CDS_REG_TXFAIL      16'h1A88
`define CDS_REG_TPAT        16'h1A8C
`define CDS_REG_IRQ_STAT    16'h1A90
`define CDS_REG_IRQ_CLR     16'h1A94
`define CDS_REG_IRQ_EN      16'h1A98
`define CDS_REG_LOG_PTR     16'h1A9C
`define CDS_LOG_BASE_HI     8'h1B

// ==========================================================
// field positions
`define CDS_LED_EN_BIT      0
`define CDS_LED_MODE_LSB    8
`define CDS_BLEM_EN_BIT     0
`define CDS_BLEM_BIN_BIT    1
`define CDS_TPAT_EN_BIT     0
`define CDS_LOG_WRAP_BIT    8
`define CDS_IRQ_TXFAIL      0
`define CDS_IRQ_RECONN      1
`define CDS_IRQ_FAULT       2
`define CDS_IRQ_W           3

// ==========================================================
// reset values
`define CDS_LED_EN_RST      1'b1
`define CDS_BLEM_EN_RST     1'b1
`define CDS_TPAT_EN_RST     1'b0
`define CDS_IRQ_EN_RST      3'h0

`endif

/* cds_pkg.sv */
`include "cds_consts.svh"

package cds_pkg;

  typedef enum logic [1:0] {ST_POWERUP, ST_LOAD, ST_RUN} cds_phase_t;

  typedef enum logic [2:0]
  {
    LM_POWERUP, LM_LOAD, LM_BLINK, LM_CONNECT,
    LM_STREAM, LM_FWUPD, LM_FAULT, LM_IDLE
  } cds_led_mode_t;

  typedef enum logic [1:0]
  {
    AK_PERSIST, AK_DHCP, AK_LLA, AK_FAIL
  } cds_addr_kind_t;

  typedef struct packed
  {
    logic green;
    logic red;
    logic high;
  } cds_led_t;

  typedef struct packed
  {
    logic                  valid;
    logic                  sof;
    logic                  eol;
    logic                  defect;
    logic [`CDS_PIX_W-1:0] data;
  } cds_pix_t;

  typedef struct packed
  {
    cds_phase_t             phase;
    logic [12:0]            stage_ms;
    logic [16:0]            ms_div;
    logic [9:0]             ms_cnt;
    logic [31:0]            uptime;
    logic [31:0]            linkup;
    logic                   reconn;
    logic                   link_s1;
    logic                   link_s2;
    logic                   link_prev;
    logic                   had_link;
    logic [31:0]            txfail;
    logic                   fault_prev;
    logic [`CDS_IRQ_W-1:0]  irq_stat;
    logic [`CDS_IRQ_W-1:0]  irq_en;
    logic                   led_en;
    logic                   blem_en;
    logic                   tp_en;
    logic                   bl_act;
    cds_addr_kind_t         bl_kind;
    logic [7:0]             slot_ms;
    logic [2:0]             slot_idx;
    cds_led_mode_t          mode;
    cds_led_t               led;
    logic                   wb_ack;
    logic [31:0]            wb_dat;
    logic [7:0]             log_wptr;
    logic                   log_wrap;
    logic [7:0]             col;
    logic [7:0]             row;
    cds_pix_t               fifo;
  } cds_state_t;

endpackage : cds_pkg

/* cds_blemish.sv */
`include "cds_consts.svh"

module cds_blemish
  import cds_pkg::*;
#(
  parameter int P_STRIDE = 2
)(
  input  wire logic     i_core_clk,
  input  wire logic     i_rst_n,
  input  wire logic     i_en,
  input  wire cds_pix_t i_pix,
  output cds_pix_t      o_pix
);

  localparam int C_TAPS = 2 * P_STRIDE + 1;

  typedef struct packed
  {
    cds_pix_t [C_TAPS-1:0] win;
    cds_pix_t              out;
  } cds_blem_state_t;

  cds_blem_state_t       q;
  cds_blem_state_t       d;
  logic [`CDS_PIX_W:0]   sum;
  logic [`CDS_PIX_W-1:0] avg;
  logic [`CDS_PIX_W-1:0] ctr_data;

  // ==========================================================
  // neighbour average, same colour plane on both sides
  always_comb
  begin
    d = q;
    sum = {1'b0, q.win[0].data} + {1'b0, q.win[C_TAPS-1].data};
    avg = sum[`CDS_PIX_W:1];
    ctr_data = q.win[P_STRIDE].data;
    d.out.valid = 1'b0;
    if (i_pix.valid)
    begin
      d.win = {q.win[C_TAPS-2:0], i_pix};
      d.out = q.win[P_STRIDE];
      if (i_en && q.win[P_STRIDE].defect)
      begin
        d.out.data = avg;
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end

  assign o_pix = q.out;

  AST_BLEM_AVG: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    i_pix.valid && i_en && q.win[P_STRIDE].valid && q.win[P_STRIDE].defect
    |=> o_pix.valid && o_pix.data == $past(avg))
    else $error("defect pixel not replaced by neighbour average");

  AST_BLEM_BYPASS: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    i_pix.valid && !i_en && q.win[P_STRIDE].valid
    |=> o_pix.valid && o_pix.data == $past(ctr_data))
    else $error("pixel altered while correction bypassed");

endmodule : cds_blemish

/* cds_diag.sv */
`include "cds_consts.svh"

// Operation
// - uptime seconds counter cleared only by power-up
// - link seconds counter restarts on reconnection
// - count arbitration loss with fifo overflow
// - host reads 256-byte message log
// - user can switch indicator off
// - power-up: steady bright green about five seconds
// - logic load: alternate green and red
// - address attempts shown by green/red blink counts
// - connecting: fast dim green flashing
// - streaming: steady bright green
// - firmware update: fast red/green alternation
// - fault: slow red flashing
// - test pattern injected just before fifo
// - blemish correction enable resets on
// - blemish pixel replaced by neighbour average
// - no blemish correction while binning
module cds_diag
  import cds_pkg::*;
#(
  parameter int P_MS_CYCLES = `CDS_MS_CYCLES,
  parameter int P_STRIDE    = 2
)(
  input  wire logic           i_core_clk,
  input  wire logic           i_rst_n,
  input  wire logic           i_wb_cyc,
  input  wire logic           i_wb_stb,
  input  wire logic           i_wb_we,
  input  wire logic [15:0]    i_wb_adr,
  input  wire logic [3:0]     i_wb_sel,
  input  wire logic [31:0]    i_wb_dat,
  output logic                o_wb_ack,
  output logic [31:0]         o_wb_dat,
  input  wire logic           i_link_up,
  input  wire logic           i_arb_lost,
  input  wire logic           i_fifo_ovf,
  input  wire logic           i_log_wr,
  input  wire logic [7:0]     i_log_byte,
  input  wire logic           i_load_done,
  input  wire logic           i_addr_try,
  input  wire cds_addr_kind_t i_addr_kind,
  input  wire logic           i_connecting,
  input  wire logic           i_streaming,
  input  wire logic           i_fw_update,
  input  wire logic           i_fault,
  input  wire logic           i_binning,
  input  wire cds_pix_t       i_pix,
  output cds_pix_t            o_fifo_pix,
  output cds_led_t            o_led,
  output logic                o_irq
);

  cds_state_t            q;
  cds_state_t            d;
  logic [7:0]            log_mem [`CDS_LOG_BYTES];
  cds_pix_t              bl_pix;
  logic                  ms_tick;
  logic                  sec_tick;
  logic                  reconn_ev;
  logic                  txfail_ev;
  logic                  fault_ev;
  logic                  acc;
  logic [15:0]           adr_w;
  logic [5:0]            log_idx;
  logic [31:0]           rd;
  logic [`CDS_IRQ_W-1:0] irq_clr;
  logic [`CDS_IRQ_W-1:0] irq_ev;
  logic [2:0]            bl_n;
  logic                  bl_lit;
  logic                  fast;
  logic                  slow;
  logic                  ldalt;
  cds_led_mode_t         mode;
  cds_led_t              led_n;
  logic [7:0]            cur_col;
  logic [7:0]            cur_row;

  // ==========================================================
  // blemish correction stage
  cds_blemish #(
    .P_STRIDE (P_STRIDE)
  ) u_blemish (
    .i_core_clk (i_core_clk),
    .i_rst_n    (i_rst_n),
    .i_en       (q.blem_en && !i_binning),
    .i_pix      (i_pix),
    .o_pix      (bl_pix)
  );

  // ==========================================================
  // next state
  always_comb
  begin
    d = q;
    ms_tick = 1'b0;
    if (q.ms_div == 17'(P_MS_CYCLES - 1))
    begin
      d.ms_div = '0;
      ms_tick = 1'b1;
    end
    else
    begin
      d.ms_div = q.ms_div + 17'h1;
    end
    sec_tick = ms_tick && (q.ms_cnt == `CDS_SEC_LAST_MS);
    if (ms_tick)
    begin
      d.ms_cnt = sec_tick ? 10'h0 : q.ms_cnt + 10'h1;
    end

    // time counters
    if (sec_tick)
    begin
      d.uptime = q.uptime + 32'h1;
    end
    d.link_s1 = i_link_up;
    d.link_s2 = q.link_s1;
    d.link_prev = q.link_s2;
    if (q.link_s2)
    begin
      d.had_link = 1'b1;
    end
    reconn_ev = q.link_s2 && !q.link_prev && q.had_link;
    if (reconn_ev)
    begin
      d.linkup = 32'h0;
      d.reconn = 1'b1;
    end
    else if (sec_tick)
    begin
      d.linkup = q.linkup + 32'h1;
    end

    txfail_ev = i_arb_lost && i_fifo_ovf;
    if (txfail_ev)
    begin
      d.txfail = q.txfail + 32'h1;
    end
    d.fault_prev = i_fault;
    fault_ev = i_fault && !q.fault_prev;

    // message log write pointer
    if (i_log_wr)
    begin
      d.log_wptr = q.log_wptr + 8'h1;
      if (q.log_wptr == 8'hFF)
      begin
        d.log_wrap = 1'b1;
      end
    end

    // start-up phases
    unique case (q.phase)
      ST_POWERUP:
      begin
        if (ms_tick)
        begin
          if (q.stage_ms == 13'(`CDS_POWERUP_MS - 1))
          begin
            d.phase = ST_LOAD;
            d.stage_ms = '0;
          end
          else
          begin
            d.stage_ms = q.stage_ms + 13'h1;
          end
        end
      end
      ST_LOAD:
      begin
        if (q.stage_ms >= 13'(`CDS_LOAD_MS - 1))
        begin
          if (i_load_done)
          begin
            d.phase = ST_RUN;
          end
        end
        else if (ms_tick)
        begin
          d.stage_ms = q.stage_ms + 13'h1;
        end
      end
      ST_RUN:
      begin
        d.stage_ms = q.stage_ms;
      end
      default:
      begin
        d.phase = ST_POWERUP;
      end
    endcase

    // address attempt blink window
    if (i_addr_try)
    begin
      d.bl_act = 1'b1;
      d.bl_kind = i_addr_kind;
      d.slot_ms = '0;
      d.slot_idx = '0;
    end
    else if (q.bl_act && ms_tick)
    begin
      if (q.slot_ms == `CDS_BLINK_SLOT_MS - 8'h1)
      begin
        d.slot_ms = '0;
        if (q.slot_idx == `CDS_BLINK_SLOTS - 3'h1)
        begin
          d.bl_act = 1'b0;
        end
        else
        begin
          d.slot_idx = q.slot_idx + 3'h1;
        end
      end
      else
      begin
        d.slot_ms = q.slot_ms + 8'h1;
      end
    end
    unique case (q.bl_kind)
      AK_PERSIST: bl_n = 3'h1;
      AK_DHCP:    bl_n = 3'h2;
      AK_LLA:     bl_n = 3'h3;
      AK_FAIL:    bl_n = 3'h3;
    endcase
    bl_lit = q.bl_act && (q.slot_idx < bl_n)
             && (q.slot_ms < `CDS_BLINK_ON_MS);

    // indicator mode, highest priority first
    if (i_fault)
      mode = LM_FAULT;
    else if (i_fw_update)
      mode = LM_FWUPD;
    else if (q.phase == ST_POWERUP)
      mode = LM_POWERUP;
    else if (q.phase == ST_LOAD)
      mode = LM_LOAD;
    else if (q.bl_act)
      mode = LM_BLINK;
    else if (i_streaming)
      mode = LM_STREAM;
    else if (i_connecting)
      mode = LM_CONNECT;
    else
      mode = LM_IDLE;
    d.mode = mode;

    fast = q.ms_cnt[`CDS_FAST_BIT];
    ldalt = q.ms_cnt[`CDS_LOAD_BIT];
    slow = q.ms_cnt < `CDS_SLOW_HALF_MS;
    led_n = '0;
    unique case (mode)
      LM_POWERUP: led_n = '{green: 1'b1, red: 1'b0, high: 1'b1};
      LM_LOAD:    led_n = '{green: ldalt, red: !ldalt, high: 1'b1};
      LM_BLINK:
      begin
        led_n.high = 1'b1;
        if (q.bl_kind == AK_FAIL)
          led_n.red = bl_lit;
        else
          led_n.green = bl_lit;
      end
      LM_CONNECT: led_n = '{green: fast, red: 1'b0, high: 1'b0};
      LM_STREAM:  led_n = '{green: 1'b1, red: 1'b0, high: 1'b1};
      LM_FWUPD:   led_n = '{green: !fast, red: fast, high: 1'b1};
      LM_FAULT:   led_n = '{green: 1'b0, red: slow, high: 1'b1};
      LM_IDLE:    led_n = '{green: 1'b1, red: 1'b0, high: 1'b0};
    endcase
    d.led = q.led_en ? led_n : '0;

    // register slave
    acc = i_wb_cyc && i_wb_stb && !q.wb_ack;
    d.wb_ack = acc;
    adr_w = {i_wb_adr[15:2], 2'b00};
    log_idx = i_wb_adr[7:2];
    irq_clr = '0;
    rd = '0;
    case (adr_w)
      `CDS_REG_LED:
      begin
        rd[`CDS_LED_EN_BIT] = q.led_en;
        rd[`CDS_LED_MODE_LSB +: 3] = q.mode;
        if (acc && i_wb_we && i_wb_sel[0])
          d.led_en = i_wb_dat[`CDS_LED_EN_BIT];
      end
      `CDS_REG_BLEM:
      begin
        rd[`CDS_BLEM_EN_BIT] = q.blem_en;
        rd[`CDS_BLEM_BIN_BIT] = i_binning;
        if (acc && i_wb_we && i_wb_sel[0])
          d.blem_en = i_wb_dat[`CDS_BLEM_EN_BIT];
      end
      `CDS_REG_UPTIME: rd = q.uptime;
      `CDS_REG_LINKUP: rd = q.linkup;
      `CDS_REG_TXFAIL: rd = q.txfail;
      `CDS_REG_TPAT:
      begin
        rd[`CDS_TPAT_EN_BIT] = q.tp_en;
        if (acc && i_wb_we && i_wb_sel[0])
          d.tp_en = i_wb_dat[`CDS_TPAT_EN_BIT];
      end
      `CDS_REG_IRQ_STAT: rd[`CDS_IRQ_W-1:0] = q.irq_stat;
      `CDS_REG_IRQ_CLR:
      begin
        if (acc && i_wb_we && i_wb_sel[0])
          irq_clr = i_wb_dat[`CDS_IRQ_W-1:0];
      end
      `CDS_REG_IRQ_EN:
      begin
        rd[`CDS_IRQ_W-1:0] = q.irq_en;
        if (acc && i_wb_we && i_wb_sel[0])
          d.irq_en = i_wb_dat[`CDS_IRQ_W-1:0];
      end
      `CDS_REG_LOG_PTR:
      begin
        rd[7:0] = q.log_wptr;
        rd[`CDS_LOG_WRAP_BIT] = q.log_wrap;
      end
      default:
      begin
        if (adr_w[15:8] == `CDS_LOG_BASE_HI)
          rd = {log_mem[{log_idx, 2'd3}], log_mem[{log_idx, 2'd2}],
                log_mem[{log_idx, 2'd1}], log_mem[{log_idx, 2'd0}]};
      end
    endcase
    if (acc)
    begin
      d.wb_dat = i_wb_we ? 32'h0 : rd;
    end

    // sticky events, a new event beats a clear
    irq_ev = '0;
    irq_ev[`CDS_IRQ_TXFAIL] = txfail_ev;
    irq_ev[`CDS_IRQ_RECONN] = reconn_ev;
    irq_ev[`CDS_IRQ_FAULT] = fault_ev;
    d.irq_stat = (q.irq_stat & ~irq_clr) | irq_ev;

    // test pattern ahead of the fifo
    cur_col = bl_pix.sof ? 8'h0 : q.col;
    cur_row = bl_pix.sof ? 8'h0 : q.row;
    d.fifo = bl_pix;
    if (bl_pix.valid)
    begin
      d.col = bl_pix.eol ? 8'h0 : cur_col + 8'h1;
      d.row = bl_pix.eol ? cur_row + 8'h1 : cur_row;
      if (q.tp_en)
        d.fifo.data = `CDS_PIX_W'({cur_row, cur_col});
    end
  end

  // ==========================================================
  // state registers
  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      q <= '0;
      q.led_en <= `CDS_LED_EN_RST;
      q.blem_en <= `CDS_BLEM_EN_RST;
      q.tp_en <= `CDS_TPAT_EN_RST;
      q.irq_en <= `CDS_IRQ_EN_RST;
    end
    else
    begin
      q <= d;
    end
  end

  // log storage, not reset
  always_ff @(posedge i_core_clk)
  begin
    if (i_log_wr)
    begin
      log_mem[q.log_wptr] <= i_log_byte;
    end
  end

  assign o_wb_ack = q.wb_ack;
  assign o_wb_dat = q.wb_dat;
  assign o_led = q.led;
  assign o_fifo_pix = q.fifo;
  assign o_irq = |(q.irq_stat & q.irq_en);

  // ==========================================================
  // checks
  AST_UPTIME_STEP: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    sec_tick |=> q.uptime == $past(q.uptime) + 32'h1)
    else $error("uptime did not advance on second tick");

  AST_LINK_EQ: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    !q.reconn |-> q.linkup == q.uptime)
    else $error("link time differs from uptime before reconnection");

  AST_TXFAIL: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    i_arb_lost && i_fifo_ovf |=> q.txfail == $past(q.txfail) + 32'h1)
    else $error("transmit failure not counted");

  AST_LOG_PTR: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    i_log_wr |=> q.log_wptr == $past(q.log_wptr) + 8'h1)
    else $error("log pointer did not advance");

  AST_LED_DARK: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    !q.led_en |=> !o_led.green && !o_led.red && !o_led.high)
    else $error("indicator lit while disabled");

  AST_POWERUP: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    mode == LM_POWERUP && q.led_en |=> o_led.green && !o_led.red && o_led.high)
    else $error("power-up indicator not bright green");

  AST_LOAD_ALT: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    mode == LM_LOAD && q.led_en |=> o_led.green != o_led.red)
    else $error("load indicator not alternating");

  AST_FAIL_RED: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    mode == LM_BLINK && q.bl_kind == AK_FAIL |=> !o_led.green)
    else $error("address failure blinked green");

  AST_CONNECT: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    mode == LM_CONNECT |=> !o_led.red && !o_led.high)
    else $error("connecting indicator not dim green");

  AST_STREAM: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    mode == LM_STREAM && q.led_en |=> o_led.green && o_led.high && !o_led.red)
    else $error("streaming indicator not steady green");

  AST_FWUPD: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    mode == LM_FWUPD && q.led_en |=> o_led.green ^ o_led.red)
    else $error("update indicator not alternating");

  AST_FAULT: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    i_fault |=> !o_led.green)
    else $error("fault indicator shows green");

  AST_TPAT: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    q.tp_en && bl_pix.valid && bl_pix.sof |=> o_fifo_pix.valid
    && o_fifo_pix.data == '0)
    else $error("test pattern missing at frame start");

  AST_BLEM_RST: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    $rose(i_rst_n) |-> q.blem_en)
    else $error("blemish correction off after reset");

endmodule : cds_diag

/* cds_host.sv */
module cds_host
(
  input  wire logic        i_core_clk,
  input  wire logic        i_ack,
  input  wire logic [31:0] i_rdat,
  output logic             o_cyc,
  output logic             o_stb,
  output logic             o_we,
  output logic [15:0]      o_adr,
  output logic [3:0]       o_sel,
  output logic [31:0]      o_dat
);
  timeunit 1ns;
  timeprecision 1ps;

  // ======
  // host side: classic cycle held until ack sampled
  initial {o_cyc, o_stb, o_we, o_adr, o_sel, o_dat} = '0;

  task automatic xfer(input logic w, input logic [15:0] a,
                      input logic [31:0] d, output logic [31:0] r);
    @(posedge i_core_clk);
    {o_cyc, o_stb, o_we, o_sel} <= {2'h3, w, 4'hF};
    o_adr <= a;
    o_dat <= d;
    @(posedge i_core_clk);
    while (i_ack !== 1'b1)
      @(posedge i_core_clk);
    r = i_rdat;
    {o_cyc, o_stb} <= 2'h0;
    // released lines wander
    o_adr <= ~a;
    o_dat <= ~d;
  endtask : xfer
endmodule : cds_host

/* cds_diag_tb_top.sv */
`include "cds_consts.svh"

module cds_diag_tb_top
  import cds_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;

  localparam int P_MS  = 4;
  localparam int P_SEC = 1000 * P_MS;

  logic           clk, rst_n, cyc, stb, we, ack, link, arb, ovf, lwr;
  logic           ldone, atry, conn, strm, fwu, flt, bin, irq, pv;
  logic [2:0]     lv, on, off;
  logic [3:0]     sel;
  logic [7:0]     lbyte;
  logic [7:0]     lb [8];
  logic [15:0]    adr;
  logic [15:0]    got [$];
  logic [15:0]    exp_q [$];
  logic [31:0]    wdat, rdat, q, u;
  cds_addr_kind_t akind;
  cds_pix_t       pix, fpix;
  cds_led_t       led;
  int             n_errors = 0, cmp_count = 0, seed = 98352;
  int             cyc_n = 0, skip = 0, n, nb, t_re;

  assign lv = led;

  cds_host cds_host_i (.i_core_clk(clk), .i_ack(ack), .i_rdat(rdat),
    .o_cyc(cyc), .o_stb(stb), .o_we(we), .o_adr(adr), .o_sel(sel),
    .o_dat(wdat));

  cds_diag #(.P_MS_CYCLES(P_MS), .P_STRIDE(2)) cds_diag_i (
    .i_core_clk(clk), .i_rst_n(rst_n), .i_wb_cyc(cyc), .i_wb_stb(stb),
    .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat),
    .o_wb_ack(ack), .o_wb_dat(rdat), .i_link_up(link), .i_arb_lost(arb),
    .i_fifo_ovf(ovf), .i_log_wr(lwr), .i_log_byte(lbyte),
    .i_load_done(ldone), .i_addr_try(atry), .i_addr_kind(akind),
    .i_connecting(conn), .i_streaming(strm), .i_fw_update(fwu),
    .i_fault(flt), .i_binning(bin), .i_pix(pix), .o_fifo_pix(fpix),
    .o_led(led), .o_irq(irq));

  // ======
  // clock, cycle count, pixel monitor
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  always @(posedge clk or negedge rst_n)
    if (!rst_n)
      cyc_n <= 0;
    else
      cyc_n <= cyc_n + 1;

  always @(posedge clk)
    if (fpix.valid === 1'b1 && skip > 0)
      skip--;
    else if (fpix.valid === 1'b1)
      got.push_back(fpix.data);

  // ======
  // helpers
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic rd(logic [15:0] a);
    cds_host_i.xfer(1'b0, a, 32'h0, q);
  endtask : rd

  task automatic wr(logic [15:0] a, logic [31:0] d);
    cds_host_i.xfer(1'b1, a, d, q);
  endtask : wr

  task automatic rc(string nm, logic [15:0] a, logic [31:0] m, e);
    rd(a);
    chk(nm, e, q & m);
  endtask : rc

  // seconds counters may tick between sample and read
  function automatic logic [31:0] near(logic [31:0] g, int s);
    return (g == s + 1 || g == s - 1) ? s : g;
  endfunction : near

  task automatic wait_to(int t);
    while (cyc_n < t)
      @(posedge clk);
  endtask : wait_to

  task automatic watch(int t);
    on = '0;
    off = '0;
    repeat (t)
    begin
      @(negedge clk);
      on |= lv;
      off |= ~lv;
    end
    @(posedge clk);
  endtask : watch

  task automatic px(logic s, logic df, logic [15:0] d);
    @(posedge clk);
    pix <= '{1'b1, s, 1'b0, df, d};
  endtask : px

  task automatic run(logic en, logic bn);
    logic [15:0] d [10];
    foreach (d[k])
      d[k] = 16'($random(seed));
    wr(`CDS_REG_BLEM, {31'h0, en});
    @(posedge clk);
    bin <= bn;
    rc("bin", `CDS_REG_BLEM, 32'h3, {bn, en});
    foreach (d[k])
    begin
      px(k == 0, k == 4, d[k]);
      exp_q.push_back((k == 4 && en && !bn) ?
        16'((17'(d[2]) + d[6]) >> 1) : d[k]);
    end
    @(posedge clk);
    pix <= '0;
  endtask : run

  task automatic stop_test;
    $display("compares %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : stop_test

  initial
  begin
    repeat (80000) @(posedge clk);
    n_errors++;
    stop_test;
  end

  // ======
  // main sequence
  initial
  begin
    {rst_n, arb, ovf, lwr, atry, conn, strm, fwu, flt, bin} = '0;
    {link, ldone} = 2'h3;
    lbyte = 8'h00;
    pix = '0;
    akind = AK_PERSIST;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    rc("led_ctl", `CDS_REG_LED, 32'h701, 32'h1);
    rc("blem_ctl", `CDS_REG_BLEM, 32'h1, 32'h1);
    rc("tpat", `CDS_REG_TPAT, 32'h1, 32'h0);
    rc("unmapped", 16'h1A00, '1, 32'h0);
    chk("led_pwr", 3'h5, lv);
    n = 3 + ($random(seed) & 7);
    for (int k = 0; k < 3 * n; k++)
    begin
      @(posedge clk);
      {arb, ovf} <= (k % 3 == 0) ? 2'h3 : 2'(k % 3);
    end
    @(posedge clk);
    {arb, ovf} <= 2'h0;
    rc("txfail", `CDS_REG_TXFAIL, '1, n);
    rc("irq_stat", `CDS_REG_IRQ_STAT, 32'h7, 32'h1);
    wr(`CDS_REG_IRQ_EN, 32'h7);
    @(negedge clk);
    chk("irq_set", 1'b1, irq);
    wr(`CDS_REG_IRQ_CLR, 32'h1);
    @(negedge clk);
    chk("irq_clr", 1'b0, irq);
    rc("clr_read", `CDS_REG_IRQ_CLR, '1, 32'h0);
    $display("test counters done");
    foreach (lb[k])
    begin
      lb[k] = 8'($random(seed));
      @(posedge clk);
      {lwr, lbyte} <= {1'b1, lb[k]};
    end
    @(posedge clk);
    lwr <= 1'b0;
    rc("log_lo", 16'h1B00, '1, {lb[3], lb[2], lb[1], lb[0]});
    rc("log_hi", 16'h1B04, '1, {lb[7], lb[6], lb[5], lb[4]});
    rc("log_ptr", `CDS_REG_LOG_PTR, 32'h1FF, 32'h8);
    wr(`CDS_REG_TPAT, 32'h1);
    for (int k = 0; k < 10; k++)
      px(k == 0, k == 4, 16'($random(seed)));
    @(posedge clk);
    pix <= '0;
    wr(`CDS_REG_TPAT, 32'h0);
    // window holds five pixels, three still unsent; the last three leave with tp off
    for (int k = 0; k < 7; k++)
      exp_q.push_back({8'h00, 8'(k)});
    skip = 3;
    run(1'b1, 1'b0);
    run(1'b1, 1'b1);
    run(1'b0, 1'b0);
    repeat (4) @(posedge clk);
    chk("pix_cnt", exp_q.size() - 3, got.size());
    foreach (got[k])
      chk("pix", exp_q[k], got[k]);
    $display("test log and pixels done");
    wr(`CDS_REG_LED, 32'h0);
    @(negedge clk);
    chk("led_off", 3'h0, lv);
    rc("mode_kept", `CDS_REG_LED, 32'h701, 32'h0);
    wr(`CDS_REG_LED, 32'h1);
    @(negedge clk);
    chk("led_back", 3'h5, lv);
    wait_to(19900);
    rc("mode_pwr", `CDS_REG_LED, 32'h700, 32'h0);
    wait_to(20100);
    rc("mode_load", `CDS_REG_LED, 32'h700, 32'h100);
    watch(2100);
    chk("load_alt", 4'hF, {on[2:1], off[2:1]});
    wait_to(22400);
    rd(`CDS_REG_UPTIME);
    u = q;
    chk("uptime", cyc_n / P_SEC, near(q, cyc_n / P_SEC));
    rd(`CDS_REG_LINKUP);
    chk("link_eq", u, q);
    link <= 1'b0;
    repeat (20) @(posedge clk);
    link <= 1'b1;
    t_re = cyc_n;
    wait_to(27000);
    rd(`CDS_REG_UPTIME);
    chk("uptime2", cyc_n / P_SEC, near(q, cyc_n / P_SEC));
    rd(`CDS_REG_LINKUP);
    u = (cyc_n - t_re) / P_SEC;
    chk("linkup", u, near(q, u));
    rc("irq_reconn", `CDS_REG_IRQ_STAT, 32'h2, 32'h2);
    $display("test power-up and timers done");
    wait_to(28400);
    strm <= 1'b1;
    rc("mode_strm", `CDS_REG_LED, 32'h700, 32'h400);
    chk("led_strm", 3'h5, lv);
    {strm, conn} <= 2'h1;
    rc("mode_conn", `CDS_REG_LED, 32'h700, 32'h300);
    watch(600);
    chk("conn", 6'h27, {on, off});
    {conn, fwu} <= 2'h1;
    rc("mode_fw", `CDS_REG_LED, 32'h700, 32'h500);
    watch(600);
    chk("fw", 4'hF, {on[2:1], off[2:1]});
    flt <= 1'b1;
    rc("mode_flt", `CDS_REG_LED, 32'h700, 32'h600);
    rc("irq_flt", `CDS_REG_IRQ_STAT, 32'h4, 32'h4);
    watch(4400);
    chk("fault", 3'h3, {on[2:1], off[1]});
    {fwu, flt} <= 2'h0;
    rc("mode_idle", `CDS_REG_LED, 32'h700, 32'h700);
    chk("led_idle", 3'h4, lv);
    for (int k = 0; k < 4; k++)
    begin
      @(posedge clk);
      atry <= 1'b1;
      akind <= cds_addr_kind_t'(k);
      @(posedge clk);
      atry <= 1'b0;
      rc("mode_blink", `CDS_REG_LED, 32'h700, 32'h200);
      {nb, pv, on} = '0;
      repeat (5800)
      begin
        @(negedge clk);
        nb += int'(|lv[2:1] && !pv);
        pv = |lv[2:1];
        on |= lv;
      end
      chk("blinks", (k < 3) ? k + 1 : 3, nb);
      chk("blink_hue", (k < 3) ? 2'h2 : 2'h1, on[2:1]);
      repeat (600) @(posedge clk);
    end
    $display("test indicator modes done");
    wr(`CDS_REG_LED, 32'h0);
    rst_n <= 1'b0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    rc("led_rst", `CDS_REG_LED, 32'h1, 32'h1);
    rc("tx_rst", `CDS_REG_TXFAIL, '1, 32'h0);
    rc("up_rst", `CDS_REG_UPTIME, '1, 32'h0);
    $display("test power cycle done");
    stop_test;
  end
endmodule : cds_diag_tb_top
